// *** logic/data_space_access_unit.sv ***
/*
 Data-space access unit: address decode, I/O bit ops, 16-bit atomic access,
 EEPROM access with halts and self-timed writes, program memory loads.
 Assumes the execution unit and peripherals share clk; por_arst_n is power-on only.
*/
`timescale 1ns/1ps
`default_nettype none
module data_space_access_unit #(
	parameter int unsigned SRAM_BYTES       = 512,
	parameter int unsigned EE_BYTES         = 512,
	parameter int unsigned PROG_WORDS       = 8192,
	parameter int unsigned EE_ATOMIC_CYCLES = data_space_pkg::EE_ATOMIC_DEF,
	parameter int unsigned EE_SPLIT_CYCLES  = data_space_pkg::EE_SPLIT_DEF
) (
	// clock and resets
	input  wire logic                         clk,
	input  wire logic                         arst_n,
	input  wire logic                         por_arst_n,
	// execution unit
	input  wire data_space_pkg::request_type  req,
	output logic                              req_ready,
	output data_space_pkg::response_type      rsp,
	output logic                              halt,
	// peripheral side
	input  wire logic [7:0]                   flag_events,
	output logic                              ee_busy,
	// program memory
	output logic [$clog2(PROG_WORDS)-1:0]     prog_addr,
	input  wire logic [15:0]                  prog_word
);
	import data_space_pkg::*;
	localparam int PC_W  = $clog2(PROG_WORDS);
	localparam int SR_W  = $clog2(SRAM_BYTES);
	localparam int EA_W  = $clog2(EE_BYTES);
	localparam int CNT_W = $clog2(EE_ATOMIC_CYCLES + 1);
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_HALT} state_type;

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val,
		input logic [7:0] m);
		return (old & ~m) | (val & m);
	endfunction

	// ==========================================================
	// reset release
	logic [1:0] rst_sync;
	logic [1:0] por_sync;
	logic       rst_n;
	logic       por_n;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	always_ff @(posedge clk or negedge por_arst_n)
	begin
		if (!por_arst_n)
			por_sync <= 2'b00;
		else
			por_sync <= {por_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];
	assign por_n = por_sync[1];

	// ==========================================================
	// state
	logic [7:0]      rf [32];
	logic [7:0]      sram [SRAM_BYTES];
	logic [7:0]      eeprom [EE_BYTES];
	state_type       state, next_state;
	logic [2:0]      halt_count, next_halt_count, master_count, next_master_count;
	logic [15:0]     wait_addr, next_wait_addr, ee_addr, next_ee_addr;
	logic            wait_prog, next_wait_prog, rdy_ie, next_rdy_ie;
	response_type    next_rsp;
	logic [7:0]      temp, next_temp, flags, next_flags, ee_data, next_ee_data;
	logic [7:0]      gs [3];
	logic [7:0]      next_gs [3];
	logic [15:0]     wide [2];
	logic [15:0]     next_wide [2];
	logic [1:0]      mode, next_mode;
	logic [PC_W-1:0] next_prog_addr;
	logic [7:0]      next_rf [32];
	logic            eng_busy, next_eng_busy, ee_we;
	logic [CNT_W-1:0] eng_count, next_eng_count;
	logic [EA_W-1:0] eng_addr, next_eng_addr;
	logic [7:0]      eng_data, next_eng_data, ee_wval;
	logic [1:0]      eng_mode, next_eng_mode;

	// ==========================================================
	// address generation
	logic [4:0]  pb;
	logic [15:0] ptr, ea, sram_off;
	logic        bitop, is_wr, take, in_sram, ee_start, ee_read, sram_we;
	logic [7:0]  mask, wval, rd_val;
	always_comb
	begin
		case (req.ptr)
			SEL_Y:   pb = PTR_Y;
			SEL_Z:   pb = PTR_Z;
			default: pb = PTR_X;
		endcase
		ptr = {rf[pb + 5'h01], rf[pb]};
		bitop = req.op inside {OP_SET_BIT, OP_CLR_BIT, OP_SKIP_SET, OP_SKIP_CLR};
		if (bitop || req.op inside {OP_IN, OP_OUT})
			ea = {10'h000, req.addr[5:0]} + IO_OFFSET;
		else
			case (req.amode)
				AM_DIRECT: ea = req.addr;
				AM_DISP:   ea = ptr + {10'h000, req.disp};
				AM_PREDEC: ea = ptr - 16'h0001;
				default:   ea = ptr;
			endcase
		sram_off = ea - SRAM_BASE;
		in_sram = (ea >= SRAM_BASE) && ({16'h0000, sram_off} < SRAM_BYTES);
		is_wr = req.op inside {OP_STORE, OP_OUT, OP_SET_BIT, OP_CLR_BIT};
		mask = (req.op inside {OP_SET_BIT, OP_CLR_BIT}) ? 8'h01 << req.bit_sel : 8'hFF;
		wval = (req.op == OP_SET_BIT) ? mask : (req.op == OP_CLR_BIT) ? 8'h00 : req.wdata;
		take = (state == ST_IDLE) && req.valid;
		if (ea < IO_BASE)
			rd_val = rf[ea[4:0]];
		else
			case (ea)
				FLAGS:     rd_val = flags;
				GS0:       rd_val = gs[0];
				GS1:       rd_val = gs[1];
				GS2:       rd_val = gs[2];
				EE_CTRL:   rd_val = {2'b00, eng_busy ? eng_mode : mode, rdy_ie,
					master_count != 3'h0, eng_busy, 1'b0};
				EE_DATA:   rd_val = ee_data;
				EE_ADDR_L: rd_val = ee_addr[7:0];
				EE_ADDR_H: rd_val = ee_addr[15:8];
				WIDE0_L:   rd_val = wide[0][7:0];
				WIDE1_L:   rd_val = wide[1][7:0];
				WIDE0_H, WIDE1_H, TEMP_ADDR: rd_val = temp;
				default:   rd_val = 8'h00;
			endcase
	end

	// ==========================================================
	// request handling
	always_comb
	begin
		next_rf = rf;
		next_state = state;
		next_halt_count = halt_count;
		next_master_count = (master_count != 3'h0) ? master_count - 3'h1 : 3'h0;
		next_wait_addr = wait_addr;
		next_wait_prog = wait_prog;
		next_rsp = '0;
		next_temp = temp;
		next_flags = flags;
		next_gs = gs;
		next_wide = wide;
		next_mode = mode;
		next_rdy_ie = rdy_ie;
		next_ee_data = ee_data;
		next_ee_addr = ee_addr;
		next_prog_addr = prog_addr;
		ee_start = 1'b0;
		ee_read = 1'b0;
		sram_we = 1'b0;
		case (state)
			ST_IDLE:
			begin
				if (take && bitop && req.addr[5:0] > BIT_LIMIT)
				begin
					next_rsp.done = 1'b1;
					next_rsp.refused = 1'b1;
				end
				else if (take && req.op == OP_PROG_LOAD)
				begin
					next_prog_addr = ptr[PC_W:1];
					next_wait_addr = ptr;
					next_wait_prog = 1'b1;
					next_state = ST_WAIT;
				end
				else if (take && in_sram)
				begin
					sram_we = is_wr;
					next_wait_addr = sram_off;
					next_wait_prog = 1'b0;
					next_state = ST_WAIT;
				end
				else if (take)
				begin
					next_rsp.done = 1'b1;
					next_rsp.rdata = rd_val;
					next_rsp.skip = bitop && !is_wr && (rd_val[req.bit_sel] == (req.op == OP_SKIP_SET));
					if (req.op == OP_LOAD && (ea == WIDE0_L || ea == WIDE1_L))
						next_temp = wide[ea[1]][15:8];
					if (is_wr)
						case (ea)
							FLAGS:     next_flags = flags & ~(wval & mask);
							GS0:       next_gs[0] = merge(gs[0], wval, mask);
							GS1:       next_gs[1] = merge(gs[1], wval, mask);
							GS2:       next_gs[2] = merge(gs[2], wval, mask);
							EE_CTRL:
							begin
								next_rdy_ie = mask[CTRL_RDY_IE] ? wval[CTRL_RDY_IE] : rdy_ie;
								if (!eng_busy)
									next_mode = 2'(merge({6'h00, mode}, wval >> 4, mask >> 4));
								if (mask[CTRL_MASTER] && wval[CTRL_MASTER])
									next_master_count = MASTER_WINDOW;
								if (mask[CTRL_STROBE] && wval[CTRL_STROBE] && master_count != 3'h0 && !eng_busy)
									ee_start = 1'b1;
								else if (mask[CTRL_READ] && wval[CTRL_READ] && !eng_busy)
									ee_read = 1'b1;
							end
							EE_DATA:   next_ee_data = merge(ee_data, wval, mask);
							EE_ADDR_L: if (!eng_busy) next_ee_addr[7:0] = req.wdata;
							EE_ADDR_H: if (!eng_busy) next_ee_addr[15:8] = req.wdata;
							WIDE0_L, WIDE1_L: next_wide[ea[1]] = {temp, req.wdata};
							WIDE0_H, WIDE1_H, TEMP_ADDR: next_temp = req.wdata;
							default:   if (ea < IO_BASE) next_rf[ea[4:0]] = req.wdata;
						endcase
					if (ee_read)
					begin
						next_ee_data = eeprom[ee_addr[EA_W-1:0]];
						next_halt_count = READ_HALT;
						next_state = ST_HALT;
					end
					if (ee_start)
					begin
						next_halt_count = WRITE_HALT;
						next_state = ST_HALT;
					end
				end
				if (take && !bitop && req.op inside {OP_LOAD, OP_STORE}
					&& req.amode inside {AM_PREDEC, AM_POSTINC})
				begin
					next_rf[pb] = ea[7:0] + ((req.amode == AM_POSTINC) ? 8'h01 : 8'h00);
					next_rf[pb + 5'h01] = (req.amode == AM_POSTINC) ? 8'((ptr + 16'h0001) >> 8) : ea[15:8];
				end
			end
			ST_WAIT:
			begin
				next_rsp.done = 1'b1;
				if (wait_prog)
					next_rsp.rdata = wait_addr[0] ? prog_word[15:8] : prog_word[7:0];
				else
					next_rsp.rdata = sram[wait_addr[SR_W-1:0]];
				next_state = ST_IDLE;
			end
			ST_HALT:
			begin
				next_halt_count = halt_count - 3'h1;
				if (halt_count == 3'h1)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
		next_flags = next_flags | flag_events;
	end

	always_ff @(posedge clk)
	begin
		rf <= next_rf;
		if (sram_we)
			sram[sram_off[SR_W-1:0]] <= req.wdata;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			halt_count <= 3'h0;
			master_count <= 3'h0;
			wait_addr <= 16'h0000;
			wait_prog <= 1'b0;
			rsp <= '0;
			temp <= 8'h00;
			flags <= 8'h00;
			gs <= '{default: 8'h00};
			wide <= '{default: 16'h0000};
			mode <= 2'h0;
			rdy_ie <= 1'b0;
			ee_data <= 8'h00;
			ee_addr <= 16'h0000;
			prog_addr <= '0;
		end
		else
		begin
			state <= next_state;
			halt_count <= next_halt_count;
			master_count <= next_master_count;
			wait_addr <= next_wait_addr;
			wait_prog <= next_wait_prog;
			rsp <= next_rsp;
			temp <= next_temp;
			flags <= next_flags;
			gs <= next_gs;
			wide <= next_wide;
			mode <= next_mode;
			rdy_ie <= next_rdy_ie;
			ee_data <= next_ee_data;
			ee_addr <= next_ee_addr;
			prog_addr <= next_prog_addr;
		end
	end

	assign req_ready = (state == ST_IDLE);
	assign halt = (state == ST_HALT);
	assign ee_busy = eng_busy;

	// ==========================================================
	// self-timed eeprom write, power-on reset only
	always_comb
	begin
		next_eng_busy = eng_busy;
		next_eng_count = eng_count;
		next_eng_addr = eng_addr;
		next_eng_data = eng_data;
		next_eng_mode = eng_mode;
		ee_we = 1'b0;
		if (eng_busy)
		begin
			if (eng_count == '0)
			begin
				next_eng_busy = 1'b0;
				ee_we = (eng_mode != 2'b11);
			end
			else
				next_eng_count = eng_count - 1'b1;
		end
		else if (ee_start)
		begin
			next_eng_busy = 1'b1;
			next_eng_count = (mode == 2'b00) ? CNT_W'(EE_ATOMIC_CYCLES - 1)
				: CNT_W'(EE_SPLIT_CYCLES - 1);
			next_eng_addr = ee_addr[EA_W-1:0];
			next_eng_data = ee_data;
			next_eng_mode = mode;
		end
		case (eng_mode)
			2'b01:   ee_wval = 8'hFF;
			2'b10:   ee_wval = eeprom[eng_addr] & eng_data;
			default: ee_wval = eng_data;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (ee_we)
			eeprom[eng_addr] <= ee_wval;
	end

	always_ff @(posedge clk or negedge por_n)
	begin
		if (!por_n)
		begin
			eng_busy <= 1'b0;
			eng_count <= '0;
			eng_addr <= '0;
			eng_data <= 8'h00;
			eng_mode <= 2'h0;
		end
		else
		begin
			eng_busy <= next_eng_busy;
			eng_count <= next_eng_count;
			eng_addr <= next_eng_addr;
			eng_data <= next_eng_data;
			eng_mode <= next_eng_mode;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	io_map_a: assert property (take && req.op == OP_OUT && req.addr[5:0] == 6'h1E
		|=> gs[0] == $past(req.wdata)) else $error("io out missed its data address");
	bit_range_a: assert property (take && bitop && req.addr[5:0] > 6'h1F
		|=> rsp.done && rsp.refused) else $error("bit op above 0x1F not refused");
	bit_only_a: assert property (take && req.op == OP_SET_BIT && req.addr[5:0] == 6'h1E
		|=> gs[0] == ($past(gs[0]) | (8'h01 << $past(req.bit_sel)))) else $error("bit set touched other bits");
	w1c_zero_a: assert property (take && is_wr && ea == FLAGS && (wval & mask) == 8'h00
		|=> (flags & $past(flags)) == $past(flags)) else $error("zero write cleared a flag");
	sram_two_a: assert property (take && in_sram && !bitop && req.op == OP_LOAD
		|=> !rsp.done ##1 rsp.done) else $error("sram access not two cycles");
	read_halt_a: assert property ($rose(halt) && $past(ee_read)
		|-> halt [*4] ##1 !halt) else $error("eeprom read halt not four cycles");
	write_halt_a: assert property ($rose(halt) && $past(ee_start)
		|-> halt [*2] ##1 !halt) else $error("eeprom write halt not two cycles");
	wide_copy_a: assert property (take && req.op == OP_STORE && ea == WIDE0_L
		|=> wide[0] == {$past(temp), $past(req.wdata)}) else $error("temp not copied on low write");
	no_master_a: assert property (take && is_wr && ea == EE_CTRL && master_count == 3'h0 && !eng_busy
		|=> !eng_busy) else $error("write started without master enable");
	master_out_a: assert property (master_count == 3'h4 |-> ##4 master_count == 3'h0)
		else $error("master enable did not time out");
	strobe_clr_a: assert property (eng_busy && eng_count == '0 |=> !eng_busy)
		else $error("busy not cleared at write end");
endmodule
`default_nettype wire

// *** include/data_space_pkg.sv ***
/*
 Constants, types and carriers for the data-space access unit.
 Assumes one 100 MHz clock shared with the instruction execution unit.
*/
// Contract
// - Low data space: 32 register file, 64 I/O, 160 extended I/O, then SRAM.
// - Extended I/O 0x60-0xFF reachable only by loads and stores.
// - I/O ops take addresses 0x00-0x3F, mapped to data address plus 0x20.
// - Bit set, clear and skip work only on I/O addresses 0x00-0x1F.
// - Bit set or clear touches only the addressed bit, flags included.
// - Writing one clears write-one-to-clear flags; writing zero leaves them.
// - Each internal SRAM access completes in two clock cycles.
// - Halt four cycles after EEPROM read, two after starting an EEPROM write.
// - EEPROM writes are self-timed and a busy status is visible.
// - A reset during an EEPROM write lets the write finish.
// - High byte goes to temp; low-byte write copies temp into high half.
// - Low-byte read latches high half into temp; high read returns temp.
// - The temporary byte is directly readable and writable.
// - EEPROM is a separate byte-addressed space of configurable size.
// - Three general storage registers; the one below 0x20 is bit-accessible.
// - Displacement reaches 63 past Y or Z; direct reaches all data space.
// - R26-R31 are pointer pairs; pre-decrement and post-increment write back.
// - Program memory words addressed by a program counter sized to the flash.
// - Master write enable clears itself four cycles after being set.
// - Write strobe bit clears when the self-timed write completes.
package data_space_pkg;
	// ==========================================================
	// data space map
	localparam logic [15:0] IO_BASE   = 16'h0020;
	localparam logic [15:0] SRAM_BASE = 16'h0100;
	localparam logic [15:0] IO_OFFSET = 16'h0020;
	localparam logic [5:0]  BIT_LIMIT = 6'h1F;
	localparam logic [15:0] FLAGS     = 16'h0036;
	localparam logic [15:0] GS0       = 16'h003E;
	localparam logic [15:0] EE_CTRL   = 16'h003F;
	localparam logic [15:0] EE_DATA   = 16'h0040;
	localparam logic [15:0] EE_ADDR_L = 16'h0041;
	localparam logic [15:0] EE_ADDR_H = 16'h0042;
	localparam logic [15:0] GS1       = 16'h004A;
	localparam logic [15:0] GS2       = 16'h004B;
	localparam logic [15:0] WIDE0_L   = 16'h0084;
	localparam logic [15:0] WIDE0_H   = 16'h0085;
	localparam logic [15:0] WIDE1_L   = 16'h0086;
	localparam logic [15:0] WIDE1_H   = 16'h0087;
	localparam logic [15:0] TEMP_ADDR = 16'h0088;
	localparam logic [4:0]  PTR_X     = 5'h1A;
	localparam logic [4:0]  PTR_Y     = 5'h1C;
	localparam logic [4:0]  PTR_Z     = 5'h1E;
	// ==========================================================
	// eeprom control fields and timing
	localparam int unsigned CTRL_READ   = 0;
	localparam int unsigned CTRL_STROBE = 1;
	localparam int unsigned CTRL_MASTER = 2;
	localparam int unsigned CTRL_RDY_IE = 3;
	localparam logic [2:0]  MASTER_WINDOW = 3'h4;
	localparam logic [2:0]  READ_HALT     = 3'h4;
	localparam logic [2:0]  WRITE_HALT    = 3'h2;
	localparam int unsigned CLK_MHZ       = 100;
	localparam int unsigned EE_ATOMIC_US  = 3400;
	localparam int unsigned EE_SPLIT_US   = 1800;
	localparam int unsigned EE_ATOMIC_DEF = EE_ATOMIC_US * CLK_MHZ;
	localparam int unsigned EE_SPLIT_DEF  = EE_SPLIT_US * CLK_MHZ;
	// ==========================================================
	// carriers
	typedef enum logic [3:0] {OP_LOAD, OP_STORE, OP_IN, OP_OUT, OP_SET_BIT, OP_CLR_BIT,
		OP_SKIP_SET, OP_SKIP_CLR, OP_PROG_LOAD} op_type;
	typedef enum logic [2:0] {AM_DIRECT, AM_INDIRECT, AM_DISP, AM_PREDEC,
		AM_POSTINC} amode_type;
	typedef enum logic [1:0] {SEL_X, SEL_Y, SEL_Z} ptr_type;
	typedef struct packed {
		logic      valid;
		op_type    op;
		amode_type amode;
		ptr_type   ptr;
		logic [5:0]  disp;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic [2:0]  bit_sel;
	} request_type;
	typedef struct packed {
		logic       done;
		logic       refused;
		logic       skip;
		logic [7:0] rdata;
	} response_type;
endpackage

// *** test/exec_unit_model.sv ***
/*
 Behavioural model of the instruction execution unit driving the access unit.
 Assumes one clock; requests change at the rising edge by non-blocking assignment.
*/
`timescale 1ns/1ps
`default_nettype none
module exec_unit_model (
	// clock
	input  wire logic                         clk,
	// access unit port
	output var  data_space_pkg::request_type  req,
	input  wire logic                         req_ready,
	input  wire data_space_pkg::response_type rsp
);
	import data_space_pkg::*;

	initial req = '0;

	// ==========================================================
	// one request: hold until taken, then wait for the answer
	task automatic access(input op_type op, input logic [15:0] a, input logic [7:0] wd,
		input logic [2:0] b, input amode_type am, input ptr_type p, input logic [5:0] d,
		output response_type r, output int lat);
		request_type q;
		int n;
		q = '0;
		q.valid = 1'b1;
		q.op = op;
		q.amode = am;
		q.ptr = p;
		q.disp = d;
		q.addr = a;
		q.wdata = wd;
		q.bit_sel = b;
		@(posedge clk);
		req <= q;
		n = 0;
		#1;
		while (req_ready !== 1'b1 && n < 50)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk);
		req <= '0;
		lat = 1;
		#1;
		while (rsp.done !== 1'b1 && lat < 50)
		begin
			@(posedge clk);
			#1;
			lat++;
		end
		r = rsp;
		if (n >= 50 || lat >= 50)
			lat = -1;
	endtask
endmodule
`default_nettype wire

// *** test/data_space_access_unit_bench.sv ***
/*
 Self-checking bench for the data-space access unit.
 Assumes the execution unit model and short EEPROM write times.
*/
`timescale 1ns/1ps
`default_nettype none
module data_space_access_unit_bench;
	import data_space_pkg::*;
	localparam int ATOM  = 20;
	localparam int SPLIT = 10;

	logic         clk;
	logic         arst_n;
	logic         por_arst_n;
	request_type  req;
	logic         req_ready;
	response_type rsp;
	logic         halt;
	logic [7:0]   flag_events;
	logic         ee_busy;
	logic [12:0]  prog_addr;
	logic [15:0]  prog_word;
	int           num_errors;
	int           checks;
	response_type r;
	int           lat;
	int           h;
	int           n;

	// ==========================================================
	// design and partner
	data_space_access_unit #(.EE_ATOMIC_CYCLES(ATOM), .EE_SPLIT_CYCLES(SPLIT)) dut (
		.clk(clk), .arst_n(arst_n), .por_arst_n(por_arst_n), .req(req),
		.req_ready(req_ready), .rsp(rsp), .halt(halt), .flag_events(flag_events),
		.ee_busy(ee_busy), .prog_addr(prog_addr), .prog_word(prog_word));
	exec_unit_model model (.clk(clk), .req(req), .req_ready(req_ready), .rsp(rsp));
	assign prog_word = {3'h5, prog_addr};

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================================
	// helpers
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic acc(input op_type op, input logic [15:0] a, input logic [7:0] wd = 8'h00,
		input logic [2:0] b = 3'h0, input amode_type am = AM_DIRECT,
		input ptr_type p = SEL_Z, input logic [5:0] d = 6'h00);
		model.access(op, a, wd, b, am, p, d, r, lat);
		if (lat < 0)
		begin
			num_errors++;
			report_and_stop;
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		acc(OP_STORE, a, v);
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		acc(OP_LOAD, a);
		check(r.rdata, exp);
	endtask

	// halt and busy cycles from the answer of a strobe onward
	task automatic meas;
		int k;
		h = 0;
		n = 0;
		k = 0;
		while ((halt === 1'b1 || ee_busy === 1'b1) && k < 300)
		begin
			if (halt === 1'b1)
				h++;
			if (ee_busy === 1'b1)
				n++;
			k++;
			@(posedge clk);
			#1;
		end
		if (k >= 300)
		begin
			num_errors++;
			report_and_stop;
		end
	endtask

	// ==========================================================
	// scenarios
	task automatic t_bits;
		wr(GS0, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			acc(OP_SET_BIT, 16'h001E, 8'h00, 3'(i));
			rd(GS0, 8'((1 << (i + 1)) - 1));
		end
		acc(OP_CLR_BIT, 16'h001E, 8'h00, 3'h3);
		rd(GS0, 8'hF7);
		acc(OP_SKIP_SET, 16'h001E, 8'h00, 3'h3);
		check({7'h00, r.skip}, 8'h00);
		acc(OP_SKIP_CLR, 16'h001E, 8'h00, 3'h3);
		check({7'h00, r.skip}, 8'h01);
		acc(OP_SKIP_SET, 16'h001E, 8'h00, 3'h4);
		check({7'h00, r.skip}, 8'h01);
		acc(OP_SET_BIT, 16'h0020, 8'h00, 3'h0);
		check({7'h00, r.refused}, 8'h01);
		rd(EE_DATA, 8'h00);
		acc(OP_SKIP_CLR, 16'h002A, 8'h00, 3'h0);
		check({7'h00, r.refused}, 8'h01);
		$display("test bits done");
	endtask

	task automatic t_space;
		acc(OP_OUT, 16'h001E, 8'h5A);
		rd(GS0, 8'h5A);
		wr(GS1, 8'h3C);
		acc(OP_IN, 16'h002A);
		check(r.rdata, 8'h3C);
		wr(GS2, 8'hC3);
		rd(GS2, 8'hC3);
		wr(16'h0005, 8'h77);
		rd(16'h0005, 8'h77);
		wr(16'h0100, 8'h11);
		check(8'(lat), 8'h02);
		rd(16'h0100, 8'h11);
		check(8'(lat), 8'h02);
		wr(16'h02FF, 8'hE4);
		rd(16'h02FF, 8'hE4);
		$display("test space done");
	endtask

	task automatic t_flags;
		@(posedge clk);
		flag_events <= 8'h81;
		@(posedge clk);
		flag_events <= 8'h00;
		rd(FLAGS, 8'h81);
		wr(FLAGS, 8'h00);
		rd(FLAGS, 8'h81);
		acc(OP_SET_BIT, 16'h0016, 8'h00, 3'h0);
		rd(FLAGS, 8'h80);
		acc(OP_CLR_BIT, 16'h0016, 8'h00, 3'h7);
		rd(FLAGS, 8'h80);
		wr(FLAGS, 8'h80);
		rd(FLAGS, 8'h00);
		$display("test flags done");
	endtask

	task automatic t_wide;
		wr(WIDE0_H, 8'h12);
		rd(TEMP_ADDR, 8'h12);
		wr(WIDE0_L, 8'h34);
		wr(TEMP_ADDR, 8'h99);
		rd(TEMP_ADDR, 8'h99);
		rd(WIDE0_L, 8'h34);
		acc(OP_IN, WIDE0_L);
		check(r.rdata, 8'h00);
		rd(WIDE0_H, 8'h12);
		wr(WIDE1_H, 8'hAB);
		rd(WIDE0_L, 8'h34);
		wr(WIDE1_L, 8'hCD);
		rd(WIDE1_L, 8'hCD);
		rd(WIDE1_H, 8'h12);
		$display("test wide done");
	endtask

	task automatic t_ptr;
		wr(16'h001A, 8'h00);
		wr(16'h001B, 8'h01);
		acc(OP_STORE, 16'h0000, 8'h5E, 3'h0, AM_POSTINC, SEL_X);
		rd(16'h0100, 8'h5E);
		rd(16'h001A, 8'h01);
		acc(OP_LOAD, 16'h0000, 8'h00, 3'h0, AM_PREDEC, SEL_X);
		check(r.rdata, 8'h5E);
		rd(16'h001A, 8'h00);
		wr(16'h001C, 8'h00);
		wr(16'h001D, 8'h01);
		wr(16'h013F, 8'h63);
		acc(OP_LOAD, 16'h0000, 8'h00, 3'h0, AM_DISP, SEL_Y, 6'h3F);
		check(r.rdata, 8'h63);
		wr(16'h001E, 8'h22);
		wr(16'h001F, 8'h01);
		acc(OP_PROG_LOAD, 16'h0000, 8'h00, 3'h0, AM_INDIRECT, SEL_Z);
		check(prog_addr[7:0], 8'h91);
		check(r.rdata, 8'h91);
		$display("test pointers done");
	endtask

	task automatic t_eeprom;
		wr(EE_ADDR_L, 8'h07);
		wr(EE_ADDR_H, 8'h00);
		acc(OP_OUT, 16'h001F, 8'h02);
		meas;
		check(8'(n), 8'h00);
		acc(OP_OUT, 16'h001F, 8'h04);
		repeat (5) @(posedge clk);
		acc(OP_SET_BIT, 16'h001F, 8'h00, 3'h1);
		meas;
		check(8'(n), 8'h00);
		for (int m = 1; m < 3; m++)
		begin
			acc(OP_OUT, 16'h001F, 8'(m << 4) | 8'h04);
			acc(OP_SET_BIT, 16'h001F, 8'h00, 3'h1);
			meas;
			check({7'h00, n >= SPLIT && n <= SPLIT + 2}, 8'h01);
		end
		acc(OP_IN, 16'h001F);
		check(r.rdata, 8'h20);
		wr(EE_DATA, 8'h6B);
		acc(OP_OUT, 16'h001F, 8'h04);
		acc(OP_SET_BIT, 16'h001F, 8'h00, 3'h1);
		acc(OP_IN, 16'h001F);
		check({7'h00, r.rdata[1]}, 8'h01);
		meas;
		check({7'h00, n >= ATOM - 3 && n <= ATOM + 2}, 8'h01);
		acc(OP_IN, 16'h001F);
		check({7'h00, r.rdata[1]}, 8'h00);
		wr(EE_DATA, 8'h00);
		acc(OP_OUT, 16'h001F, 8'h01);
		meas;
		check(8'(h), 8'h04);
		rd(EE_DATA, 8'h6B);
		wr(EE_DATA, 8'h9C);
		acc(OP_OUT, 16'h001F, 8'h04);
		acc(OP_SET_BIT, 16'h001F, 8'h00, 3'h1);
		meas;
		check(8'(h), 8'h02);
		$display("test eeprom done");
	endtask

	task automatic t_reset_write;
		wr(EE_ADDR_L, 8'h09);
		wr(EE_DATA, 8'hD2);
		acc(OP_OUT, 16'h001F, 8'h04);
		acc(OP_SET_BIT, 16'h001F, 8'h00, 3'h1);
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check({7'h00, ee_busy}, 8'h01);
		meas;
		wr(EE_ADDR_L, 8'h09);
		wr(EE_ADDR_H, 8'h00);
		acc(OP_OUT, 16'h001F, 8'h01);
		meas;
		rd(EE_DATA, 8'hD2);
		$display("test reset during write done");
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		num_errors = 0;
		checks = 0;
		arst_n = 1'b0;
		por_arst_n = 1'b0;
		flag_events = 8'h00;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		por_arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_bits;
		t_space;
		t_flags;
		t_wide;
		t_ptr;
		t_eeprom;
		t_reset_write;
		report_and_stop;
	end
endmodule
`default_nettype wire
